// [common/pcsmap_pkg.sv]
package pcsmap_pkg;
    // Operating modes, one-hot
    typedef enum logic [4:0] {
        PCSM_ILK   = 5'b0_0001,
        PCSM_B66   = 5'b0_0010,
        PCSM_B67   = 5'b0_0100,
        PCSM_XGR   = 5'b0_1000,
        PCSM_STD   = 5'b1_0000
    } pcsmap_mode_t;

    // Standard PCS lane layout: bit 0 single, bit 1 byte serializer, bit 2 PMA20 with serializer
    typedef enum logic [2:0] {
        PCSM_SER1 = 3'b001,
        PCSM_SER2 = 3'b010,
        PCSM_SER4 = 3'b100
    } pcsmap_ser_t;

    localparam int PAR_W = 80;
    localparam int DATA_W = 64;
    localparam int TXC_W = 9;
    localparam int RXC_W = 10;
    localparam int STD_TX_LANES = 4;
    localparam int STD_RX_LANES = 2;

    // Sync header codes
    localparam logic [1:0] HDR_DATA = 2'h1;
    localparam logic [1:0] HDR_CTRL = 2'h2;

    // Enhanced control-word fields
    localparam int CW_HDR_LO = 0;
    localparam int CW_INV = 2;
    localparam int CW_LOC_LO = 3;
    localparam int CW_ERR = 8;
    localparam int CW_LOCK = 9;
    localparam int CW_SHERR_LO = 8;

    // Standard PCS transmit sideband positions per lane
    localparam int TX_K_POS [STD_TX_LANES] = '{8, 19, 48, 59};
    localparam int TX_FD_POS [STD_TX_LANES] = '{9, 20, 49, 60};
    localparam int TX_DV_POS [STD_TX_LANES] = '{10, 21, 50, 61};
    localparam int TX_BYTE_POS [STD_TX_LANES] = '{0, 11, 40, 51};

    // Standard PCS receive positions per lane
    localparam int RX_K_POS [STD_RX_LANES] = '{8, 24};
    localparam int RX_BYTE_POS [STD_RX_LANES] = '{0, 16};
    localparam int RX_RM_LO = 13;

    // Rate-match status codes
    localparam logic [1:0] RM_NORMAL = 2'h0;
    localparam logic [1:0] RM_DELETE = 2'h1;
    localparam logic [1:0] RM_INSERT = 2'h2;
    localparam logic [1:0] RM_FULL = 2'h3;

    // Half of the word width, the balance point for the 67-bit disparity check
    localparam logic [6:0] DISP_BAL = 7'h20;
endpackage : pcsmap_pkg

// [common/pcsmap_if.sv]
`timescale 1ns/1ps
interface pcsmap_if;
    import pcsmap_pkg::*;
    logic [PAR_W-1:0] txParallel;
    logic [TXC_W-1:0] txControl;
    logic [PAR_W-1:0] rxParallel;
    logic [RXC_W-1:0] rxControl;
    logic rmFifoFull;
    logic rmFifoEmpty;

    modport dev (
        input txParallel,
        input txControl,
        output rxParallel,
        output rxControl,
        output rmFifoFull,
        output rmFifoEmpty
    );
    modport core (
        output txParallel,
        output txControl,
        input rxParallel,
        input rxControl,
        input rmFifoFull,
        input rmFifoEmpty
    );
endinterface : pcsmap_if

// [verilog/pcsmap_dev.sv]
`timescale 1ns/1ps
module pcsmap_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire pcsmap_pkg::pcsmap_mode_t mode,
    input wire pcsmap_pkg::pcsmap_ser_t serMode,
    input wire logic gigeMode,
    // Core link
    pcsmap_if.dev link,
    // Transmit results toward the PMA
    output logic [pcsmap_pkg::DATA_W-1:0] txDataOut,
    output logic [1:0] txHdrOut,
    output logic txInvOut,
    output logic txRdNegOut,
    output logic [pcsmap_pkg::STD_TX_LANES-1:0] txKOut,
    output logic [pcsmap_pkg::STD_TX_LANES*8-1:0] txBytesOut,
    output logic [pcsmap_pkg::STD_TX_LANES-1:0] txLaneRdNeg,
    // Receive enhanced PCS status
    input wire logic [pcsmap_pkg::DATA_W-1:0] rxData,
    input wire logic [1:0] rxHdr,
    input wire logic [4:0] rxWordLoc,
    input wire logic rxFrameErr,
    input wire logic rxBlockLock,
    input wire logic rxFrameLock,
    input wire logic [7:0] rxXgmiiCtl,
    input wire logic [1:0] rxHdrErr,
    // Receive standard PCS status
    input wire logic [pcsmap_pkg::STD_RX_LANES*8-1:0] rxBytes,
    input wire logic [pcsmap_pkg::STD_RX_LANES-1:0] rxKChar,
    input wire logic rmFull,
    input wire logic rmEmpty,
    input wire logic rmDelete,
    input wire logic rmInsert
);
    import pcsmap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Transmit enhanced path

    logic [DATA_W-1:0] txDataOut_d;
    logic [1:0] txHdrOut_d;
    logic txInvOut_d;
    logic rdNeg_q;
    logic rdNeg_d;
    logic wordHeavy;
    logic wordLight;
    logic [6:0] ones;

    function automatic logic [6:0] popCount(input logic [DATA_W-1:0] w);
        logic [6:0] n;
        n = 7'h00;
        for (int i = 0; i < DATA_W; i++) begin
            n = n + {6'h00, w[i]};
        end
        return n;
    endfunction : popCount

    assign ones = popCount(link.txParallel[DATA_W-1:0]);
    assign wordHeavy = ones > DISP_BAL;
    assign wordLight = ones < DISP_BAL;

    always_comb begin
        txDataOut_d = link.txParallel[DATA_W-1:0];
        txHdrOut_d = link.txControl[CW_HDR_LO+:2];
        txInvOut_d = 1'b0;
        rdNeg_d = rdNeg_q;
        if (mode == PCSM_B67) begin
            // Core may force inversion; otherwise we pick it to pull disparity back
            if (link.txControl[CW_INV]) begin
                txInvOut_d = 1'b1;
            end else begin
                txInvOut_d = (wordHeavy && !rdNeg_q) || (wordLight && rdNeg_q);
            end
            if (txInvOut_d) begin
                txDataOut_d = ~link.txParallel[DATA_W-1:0];
            end
            // A light word on the line pulls the running disparity negative
            if (wordHeavy != wordLight) begin
                rdNeg_d = wordLight ^ txInvOut_d;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txDataOut <= 64'h0000_0000_0000_0000;
            txHdrOut <= 2'h0;
            txInvOut <= 1'b0;
            rdNeg_q <= 1'b0;
        end else begin
            txDataOut <= txDataOut_d;
            txHdrOut <= txHdrOut_d;
            txInvOut <= txInvOut_d;
            rdNeg_q <= rdNeg_d;
        end
    end

    assign txRdNegOut = rdNeg_q;

    ////////////////////////////////////////////////////////////////////////
    // Transmit 8B/10B sideband decode

    logic [STD_TX_LANES-1:0] laneOn;
    logic [STD_TX_LANES-1:0] laneRd_q;

    assign laneOn[0] = 1'b1;
    assign laneOn[1] = serMode != PCSM_SER1;
    assign laneOn[2] = serMode == PCSM_SER4;
    assign laneOn[3] = serMode == PCSM_SER4;

    generate
        for (genvar i = 0; i < STD_TX_LANES; i++) begin : gTxLane
            logic kNext;
            logic [7:0] byteNext;
            logic rdNext;
            always_comb begin
                kNext = 1'b0;
                byteNext = 8'h00;
                rdNext = laneRd_q[i];
                if (mode == PCSM_STD && laneOn[i]) begin
                    kNext = link.txParallel[TX_K_POS[i]];
                    byteNext = link.txParallel[TX_BYTE_POS[i]+:8];
                    // Value 1 means negative disparity
                    if (link.txParallel[TX_FD_POS[i]]) begin
                        rdNext = link.txParallel[TX_DV_POS[i]];
                    end
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    txKOut[i] <= 1'b0;
                    txBytesOut[i*8+:8] <= 8'h00;
                    laneRd_q[i] <= 1'b0;
                end else begin
                    txKOut[i] <= kNext;
                    txBytesOut[i*8+:8] <= byteNext;
                    laneRd_q[i] <= rdNext;
                end
            end
        end
    endgenerate

    assign txLaneRdNeg = laneRd_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive control word

    logic [RXC_W-1:0] rxControl_d;
    logic [PAR_W-1:0] rxParallel_d;
    logic [1:0] rmStatus;

    always_comb begin
        if (rmDelete) begin
            rmStatus = RM_DELETE;
        end else if (rmInsert) begin
            rmStatus = RM_INSERT;
        end else if (rmFull) begin
            rmStatus = RM_FULL;
        end else begin
            rmStatus = RM_NORMAL;
        end
    end

    always_comb begin
        rxControl_d = '0;
        rxParallel_d = '0;
        case (mode)
            PCSM_ILK: begin
                rxParallel_d[DATA_W-1:0] = rxData;
                rxControl_d[CW_HDR_LO+:2] = rxHdr;
                rxControl_d[CW_INV] = 1'b0;
                rxControl_d[CW_LOC_LO+:5] = rxWordLoc;
                rxControl_d[CW_ERR] = rxFrameErr;
                rxControl_d[CW_LOCK] = rxBlockLock && rxFrameLock;
            end
            PCSM_B66: begin
                rxParallel_d[DATA_W-1:0] = rxData;
                rxControl_d[CW_HDR_LO+:2] = rxHdr;
                rxControl_d[CW_SHERR_LO+:2] = rxHdrErr;
            end
            PCSM_B67: begin
                rxParallel_d[DATA_W-1:0] = rxData;
                rxControl_d[CW_HDR_LO+:2] = rxHdr;
            end
            PCSM_XGR: begin
                rxParallel_d[DATA_W-1:0] = rxData;
                rxControl_d[7:0] = rxXgmiiCtl;
            end
            PCSM_STD: begin
                for (int i = 0; i < STD_RX_LANES; i++) begin
                    if (i == 0 || serMode != PCSM_SER1) begin
                        rxParallel_d[RX_BYTE_POS[i]+:8] = rxBytes[i*8+:8];
                        rxParallel_d[RX_K_POS[i]] = rxKChar[i];
                    end
                end
                rxParallel_d[RX_RM_LO+:2] = rmStatus;
            end
            default: begin
                rxControl_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.rxControl <= 10'h000;
            link.rxParallel <= '0;
        end else begin
            link.rxControl <= rxControl_d;
            link.rxParallel <= rxParallel_d;
        end
    end

    // Flags bypass the clock on purpose; the core must synchronize them
    assign link.rmFifoFull = gigeMode && rmFull;
    assign link.rmFifoEmpty = gigeMode && rmEmpty;
endmodule : pcsmap_dev

// [verilog/pcsmap_core.sv]
`timescale 1ns/1ps
module pcsmap_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire pcsmap_pkg::pcsmap_mode_t mode,
    input wire pcsmap_pkg::pcsmap_ser_t serMode,
    // Device link
    pcsmap_if.core link,
    // Transmit user fields
    input wire logic [pcsmap_pkg::DATA_W-1:0] txData,
    input wire logic txIsCtrl,
    input wire logic txInvert,
    input wire logic [pcsmap_pkg::STD_TX_LANES*8-1:0] txBytes,
    input wire logic [pcsmap_pkg::STD_TX_LANES-1:0] txKChar,
    input wire logic [pcsmap_pkg::STD_TX_LANES-1:0] txForceDisp,
    input wire logic [pcsmap_pkg::STD_TX_LANES-1:0] txDispNeg,
    // Receive user fields
    output logic [pcsmap_pkg::RXC_W-1:0] rxCtlWord,
    output logic [pcsmap_pkg::PAR_W-1:0] rxWord,
    output logic [1:0] rxRmStatus,
    output logic rmFullSync,
    output logic rmEmptySync
);
    import pcsmap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Transmit packing

    logic [PAR_W-1:0] txPar_d;
    logic [TXC_W-1:0] txCtl_d;

    always_comb begin
        txPar_d = '0;
        txCtl_d = '0;
        if (mode == PCSM_STD) begin
            for (int i = 0; i < STD_TX_LANES; i++) begin
                if (i == 0 || (i == 1 && serMode != PCSM_SER1) || serMode == PCSM_SER4) begin
                    txPar_d[TX_BYTE_POS[i]+:8] = txBytes[i*8+:8];
                    txPar_d[TX_K_POS[i]] = txKChar[i];
                    txPar_d[TX_FD_POS[i]] = txForceDisp[i];
                    txPar_d[TX_DV_POS[i]] = txDispNeg[i];
                end
            end
        end else begin
            txPar_d[DATA_W-1:0] = txData;
            txCtl_d[CW_HDR_LO+:2] = txIsCtrl ? HDR_CTRL : HDR_DATA;
            if (mode == PCSM_B67) begin
                txCtl_d[CW_INV] = txInvert;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.txParallel <= '0;
            link.txControl <= 9'h000;
        end else begin
            link.txParallel <= txPar_d;
            link.txControl <= txCtl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive capture and flag synchronizers

    logic [1:0] fullSync_q;
    logic [1:0] emptySync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCtlWord <= 10'h000;
            rxWord <= '0;
            rxRmStatus <= 2'h0;
        end else begin
            rxCtlWord <= link.rxControl;
            rxWord <= link.rxParallel;
            rxRmStatus <= link.rxParallel[RX_RM_LO+:2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fullSync_q <= 2'h0;
            emptySync_q <= 2'h0;
        end else begin
            fullSync_q <= {fullSync_q[0], link.rmFifoFull};
            emptySync_q <= {emptySync_q[0], link.rmFifoEmpty};
        end
    end

    assign rmFullSync = fullSync_q[1];
    assign rmEmptySync = emptySync_q[1];
endmodule : pcsmap_core

// [dv/pcsmap_asserts.sv]
`timescale 1ns/1ps
module pcsmap_asserts
    import pcsmap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire pcsmap_pkg::pcsmap_mode_t mode,
    input wire pcsmap_pkg::pcsmap_ser_t serMode,
    input wire logic gigeMode,
    // Link
    input wire logic [pcsmap_pkg::PAR_W-1:0] txParallel,
    input wire logic [pcsmap_pkg::TXC_W-1:0] txControl,
    input wire logic [pcsmap_pkg::PAR_W-1:0] rxParallel,
    input wire logic [pcsmap_pkg::RXC_W-1:0] rxControl,
    input wire logic rmFifoFull,
    input wire logic rmFifoEmpty
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // Two samples in one mode (encSteady: in any enhanced mode), so the registered link word was built in it
    sequence steady(m);
        (mode == m) [*2];
    endsequence
    sequence encSteady;
        (mode != PCSM_STD) [*2];
    endsequence
    sequence stdSer1;
        (mode == PCSM_STD && serMode == PCSM_SER1) [*2];
    endsequence
    ////////////////////////////////////////////////////////////
    AST_ILK_INV_ZERO: assert property (
        steady(PCSM_ILK) |-> rxControl[CW_INV] == 1'b0) else $error("ilk inversion bit set");
    AST_ILK_LOC_ONEHOT: assert property (
        steady(PCSM_ILK) |-> $onehot(rxControl[7:3])) else $error("ilk location not one-hot");
    AST_XGR_UNUSED: assert property (
        steady(PCSM_XGR) |-> rxControl[9:8] == 2'h0) else $error("xgr unused bits set");
    AST_B66_RX_UNUSED: assert property (
        steady(PCSM_B66) |-> rxControl[7:2] == 6'h00) else $error("b66 rx unused bits set");
    AST_STD_RX_CTL_ZERO: assert property (
        steady(PCSM_STD) |-> rxControl == 10'h000) else $error("std rx control not zero");
    AST_TX_HDR_LEGAL: assert property (
        encSteady |-> txControl[1:0] inside {HDR_DATA, HDR_CTRL}) else $error("bad tx header");
    AST_B66_TX_UNUSED: assert property (
        steady(PCSM_B66) |-> txControl[8:2] == 7'h00) else $error("b66 tx unused bits set");
    AST_STD_TX_LANE1_OFF: assert property (
        stdSer1 |-> txParallel[21:11] == 11'h000) else $error("tx lane one packed in single");
    AST_STD_RX_LANE1_OFF: assert property (
        stdSer1 |-> rxParallel[24:16] == 9'h000) else $error("rx lane one packed in single");
    AST_RM_FULL_GIGE: assert property (
        rmFifoFull |-> gigeMode) else $error("full flag outside gige");
    AST_RM_EMPTY_GIGE: assert property (
        rmFifoEmpty |-> gigeMode) else $error("empty flag outside gige");
endmodule : pcsmap_asserts

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import pcsmap_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pcsmap_mode_t mode = PCSM_B66;
    pcsmap_ser_t serMode = PCSM_SER1;
    logic gigeMode = 1'b0;
    logic [DATA_W-1:0] txData = '0, rxData = '0, txDataOut;
    logic txIsCtrl = 1'b0, txInvert = 1'b0, rxFrameErr = 1'b0;
    logic rxBlockLock = 1'b0, rxFrameLock = 1'b0, txInvOut, txRdNegOut;
    logic rmFull = 1'b0, rmEmpty = 1'b0, rmDelete = 1'b0, rmInsert = 1'b0;
    logic [31:0] txBytes = '0, txBytesOut;
    logic [3:0] txKChar = '0, txForceDisp = '0, txDispNeg = '0, txKOut, txLaneRdNeg;
    logic [1:0] rxHdr = HDR_DATA, rxHdrErr = '0, rxKChar = '0, txHdrOut, rxRmStatus;
    logic [4:0] rxWordLoc = 5'h01;
    logic [7:0] rxXgmiiCtl = '0;
    logic [15:0] rxBytes = '0;
    logic [9:0] rxCtlWord;
    logic [79:0] rxWord, expW;
    logic rmFullSync, rmEmptySync;
    int failures = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////
    pcsmap_if linkIf ();
    pcsmap_core pcsmap_core_inst (.clk(clk), .rst_n(rst_n), .mode(mode), .serMode(serMode),
        .link(linkIf.core), .txData(txData), .txIsCtrl(txIsCtrl), .txInvert(txInvert),
        .txBytes(txBytes), .txKChar(txKChar), .txForceDisp(txForceDisp), .txDispNeg(txDispNeg),
        .rxCtlWord(rxCtlWord), .rxWord(rxWord), .rxRmStatus(rxRmStatus),
        .rmFullSync(rmFullSync), .rmEmptySync(rmEmptySync));
    pcsmap_dev pcsmap_dev_inst (.clk(clk), .rst_n(rst_n), .mode(mode), .serMode(serMode),
        .gigeMode(gigeMode), .link(linkIf.dev), .txDataOut(txDataOut), .txHdrOut(txHdrOut),
        .txInvOut(txInvOut), .txRdNegOut(txRdNegOut), .txKOut(txKOut), .txBytesOut(txBytesOut),
        .txLaneRdNeg(txLaneRdNeg), .rxData(rxData), .rxHdr(rxHdr), .rxWordLoc(rxWordLoc),
        .rxFrameErr(rxFrameErr), .rxBlockLock(rxBlockLock), .rxFrameLock(rxFrameLock),
        .rxXgmiiCtl(rxXgmiiCtl), .rxHdrErr(rxHdrErr), .rxBytes(rxBytes), .rxKChar(rxKChar),
        .rmFull(rmFull), .rmEmpty(rmEmpty), .rmDelete(rmDelete), .rmInsert(rmInsert));
    pcsmap_asserts pcsmap_asserts_inst (.clk(clk), .rst_n(rst_n), .mode(mode),
        .serMode(serMode), .gigeMode(gigeMode), .txParallel(linkIf.txParallel),
        .txControl(linkIf.txControl), .rxParallel(linkIf.rxParallel),
        .rxControl(linkIf.rxControl), .rmFifoFull(linkIf.rmFifoFull),
        .rmFifoEmpty(linkIf.rmFifoEmpty));
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Inputs move only at the falling edge, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick
    task automatic putEnh(input logic [63:0] d, input logic c, input logic v);
        txData = d;
        txIsCtrl = c;
        txInvert = v;
    endtask : putEnh
    task automatic stop_test();
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////
    initial begin
        tick(6);
        rst_n = 1'b1;
        // Inversion request must be ignored outside the 67-bit mode
        putEnh(64'h0123_4567_89ab_cdef, 1'b1, 1'b1);
        tick(1);
        check("txParallel", linkIf.txParallel[63:0], 64'h0123_4567_89ab_cdef);
        check("txControl", linkIf.txControl, 9'h002);
        tick(1);
        check("txHdrOut", txHdrOut, HDR_CTRL);
        putEnh(64'h0123_4567_89ab_cdef, 1'b0, 1'b0);
        rxHdr = HDR_CTRL;
        rxHdrErr = 2'h2;
        rxXgmiiCtl = 8'hff;
        rxData = 64'hfeed_0000_1234_5678;
        tick(2);
        check("txHdrOut", txHdrOut, HDR_DATA);
        check("rxCtlWord", rxCtlWord, 10'h202);
        check("rxWord", rxWord[63:0], 64'hfeed_0000_1234_5678);
        mode = PCSM_ILK;
        rxHdr = HDR_DATA;
        rxBlockLock = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rxWordLoc = 5'h01 << i;
            rxFrameErr = i[0];
            rxFrameLock = (i != 2);
            tick(2);
            check("rxCtlWord", rxCtlWord, {i != 2, i[0], 5'h01 << i, 1'b0, HDR_DATA});
        end
        mode = PCSM_XGR;
        rxXgmiiCtl = 8'ha5;
        rxHdrErr = 2'h3;
        tick(2);
        check("rxCtlWord", rxCtlWord, 10'h0a5);
        // Balanced words leave running disparity alone; heavy ones flip
        mode = PCSM_B67;
        putEnh(64'h0000_0000_ffff_ffff, 1'b0, 1'b1);
        tick(1);
        check("txControl", linkIf.txControl[2:0], 3'h5);
        tick(1);
        check("txInvOut", txInvOut, 1'b1);
        check("txDataOut", txDataOut, 64'hffff_ffff_0000_0000);
        putEnh(64'h0000_0000_ffff_ffff, 1'b0, 1'b0);
        tick(2);
        check("txInvOut", txInvOut, 1'b0);
        putEnh(64'hffff_ffff_ffff_0000, 1'b0, 1'b0);
        tick(2);
        check("txInvOut", txInvOut, 1'b1);
        check("txDataOut", txDataOut, 64'h0000_0000_0000_ffff);
        check("txRdNegOut", txRdNegOut, 1'b1);
        tick(1);
        check("txInvOut", txInvOut, 1'b0);
        check("txDataOut", txDataOut, 64'hffff_ffff_ffff_0000);
        check("txRdNegOut", txRdNegOut, 1'b0);
        mode = PCSM_STD;
        serMode = PCSM_SER4;
        txBytes = 32'h4433_2211;
        txKChar = 4'h5;
        txForceDisp = 4'hf;
        txDispNeg = 4'h6;
        tick(1);
        for (int i = 0; i < STD_TX_LANES; i++) begin
            check("txK", linkIf.txParallel[TX_K_POS[i]], txKChar[i]);
            check("txForce", linkIf.txParallel[TX_FD_POS[i]], txForceDisp[i]);
            check("txDispVal", linkIf.txParallel[TX_DV_POS[i]], txDispNeg[i]);
            check("txByte", linkIf.txParallel[TX_BYTE_POS[i] +: 8], txBytes[8*i +: 8]);
        end
        tick(1);
        check("txKOut", txKOut, 4'h5);
        check("txBytesOut", txBytesOut, 32'h4433_2211);
        check("txLaneRdNeg", txLaneRdNeg, 4'h6);
        txForceDisp = 4'h0;
        txDispNeg = 4'hf;
        tick(2);
        check("txLaneRdNeg", txLaneRdNeg, 4'h6);
        serMode = PCSM_SER1;
        rxBytes = 16'hbeef;
        rxKChar = 2'h3;
        tick(2);
        check("txKOut", txKOut, 4'h1);
        check("rxWord", rxWord, 80'h0000_0000_0000_0000_01ef);
        serMode = PCSM_SER2;
        gigeMode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rmDelete = (i == 1);
            rmInsert = (i == 2);
            rmFull = (i == 1 || i == 3);
            rmEmpty = (i == 2);
            tick(2);
            expW = '0;
            expW[24:13] = {1'b1, 8'hbe, 1'b0, i[1:0]};
            expW[8:0] = 9'h1ef;
            check("rxWord", rxWord, expW);
            check("rxRmStatus", rxRmStatus, i[1:0]);
        end
        // Flags are gated combinationally, so they move without a clock
        gigeMode = 1'b0;
        rmEmpty = 1'b1;
        tick(2);
        check("rmFifoFull", linkIf.rmFifoFull, 1'b0);
        check("rmFullSync", rmFullSync, 1'b0);
        gigeMode = 1'b1;
        #1;
        check("rmFifoFull", linkIf.rmFifoFull, 1'b1);
        check("rmFifoEmpty", linkIf.rmFifoEmpty, 1'b1);
        tick(1);
        check("rmFullSync", rmFullSync, 1'b0);
        tick(1);
        check("rmFullSync", rmFullSync, 1'b1);
        check("rmEmptySync", rmEmptySync, 1'b1);
        stop_test();
    end
    initial begin
        repeat (1000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule : tb_top
